// ==== logic/mqual_pkg.sv ====
package mqual_pkg;

	// Clock and millisecond tick
	localparam int unsigned CLK_HZ   = 10_000_000;
	localparam int unsigned TICK_HZ  = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
	localparam int unsigned DIV_W    = 14;

	// Channel counts
	localparam int unsigned NUM_RED = 16;
	localparam int unsigned NUM_CH  = 18;

	// Qualification times in milliseconds
	localparam int unsigned RED_ON_MS  = 500;
	localparam int unsigned RED_OFF_MS = 200;
	localparam int unsigned GY_ON_MS   = 500;
	localparam int unsigned GY_OFF_MS  = 200;
	localparam int unsigned INH_ON_MS  = 550;
	localparam int unsigned INH_OFF_MS = 250;
	localparam int unsigned CNT_W      = 10;

	// Register bus
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_MASK   = 8'h08;
	localparam logic [ADDR_W-1:0] REG_STATE  = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_RED_ON = 8'h10;
	localparam logic [ADDR_W-1:0] REG_GRN_ON = 8'h14;
	localparam logic [ADDR_W-1:0] REG_YEL_ON = 8'h18;

	// Control fields
	localparam int unsigned CTRL_ALLOW_BIT = 0;
	localparam int unsigned CTRL_CLEAR_BIT = 1;
	localparam int unsigned CTRL_W         = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = 2'h1;

	// Status / mask fields
	localparam int unsigned STS_CABLE_LOST = 0;
	localparam int unsigned STS_FAULT      = 1;
	localparam int unsigned STS_INHIBIT    = 2;
	localparam int unsigned STS_RESET      = 3;
	localparam int unsigned STS_W          = 4;
	localparam logic [STS_W-1:0] STS_RST   = 4'h0;
	localparam logic [STS_W-1:0] MASK_RST  = 4'h0;

	// Pin synchroniser slots
	localparam int unsigned PIN_RELAY  = 0;
	localparam int unsigned PIN_CABLE  = 1;
	localparam int unsigned PIN_FRONT  = 2;
	localparam int unsigned PIN_REMOTE = 3;
	localparam int unsigned PIN_W      = 4;
	localparam logic [PIN_W-1:0] PIN_RST = 4'h2;

	// Comparator pair of one field input
	typedef struct packed {
		logic above_hi;
		logic below_lo;
	} mqual_cmp_t;

	// Readable block state
	typedef struct packed {
		logic red_fail_mon;
		logic relay_common;
		logic red_en;
		logic sf2;
		logic sf1;
		logic cable_ok;
		logic fault;
	} mqual_state_t;

endpackage

// ==== logic/mqual_top.sv ====
// Functional notes
// RULE_01 - Red 1-16, both inhibit inputs and red enable come via cable.
// RULE_02 - Unplugged red interface cable latches fault and requests flash.
// RULE_03 - Either active inhibit input blocks only red-fail monitoring.
// RULE_04 - Inhibit active after above-upper level for at least 550 ms.
// RULE_05 - Inhibit inactive below lower level or for pulses under 250 ms.
// RULE_06 - Inhibit pulses 250-550 ms may resolve either way, consistently.
// RULE_07 - Red on after above 70 Vrms level for at least 500 ms.
// RULE_08 - Red off below 50 Vrms level or for pulses under 200 ms.
// RULE_09 - Red pulses between 200 and 500 ms may classify either way.
// RULE_10 - Green or yellow on after above 25 Vrms for 500 ms.
// RULE_11 - Green or yellow off below 15 Vrms or pulses under 200 ms.
// RULE_12 - Any fault latches fault mode until front or remote reset; the code also clears it on a write of the CTRL clear bit.
// RULE_13 - Red-fail monitoring needs red enable, no inhibit, relay common off.
// RULE_14 - Red enable qualified with red thresholds, undefined band between.
// RULE_15 - Per-input millisecond counters restart on comparator change.

module mqual_filter
	import mqual_pkg::*;
#(
	parameter int unsigned ON_MS  = RED_ON_MS,
	parameter int unsigned OFF_MS = RED_OFF_MS
) (
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	input  wire logic       tick_in,
	input  wire mqual_cmp_t cmp_in,
	output logic            on_out
);

	// One extra tick so a partial first tick never shortens the time
	localparam logic [CNT_W-1:0] ON_TERM  = CNT_W'(ON_MS + 1);
	localparam logic [CNT_W-1:0] OFF_TERM = CNT_W'(OFF_MS + 1);
	localparam logic [CNT_W-1:0] MAX_TERM =
		(ON_TERM > OFF_TERM) ? ON_TERM : OFF_TERM;

	mqual_cmp_t       meta_r;
	mqual_cmp_t       sync_r;
	mqual_cmp_t       prev_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             on_r;
	logic             on_nxt;
	wire              changed;
	wire              run;
	wire              on_hit;
	wire              off_hit;

	assign changed = (sync_r != prev_r);
	assign run     = tick_in && (cnt_r < MAX_TERM);
	// Count restarts on every comparator edge
	assign cnt_nxt = changed ? '0 :
		run ? cnt_r + CNT_W'(1) : cnt_r; // RULE_15
	assign on_hit  = !changed && sync_r.above_hi &&
		(cnt_r >= ON_TERM); // RULE_04 RULE_07 RULE_10
	assign off_hit = !changed && sync_r.below_lo &&
		(cnt_r >= OFF_TERM); // RULE_05 RULE_08 RULE_11
	// Middle band and short pulses keep the previous state
	assign on_nxt  = on_hit ? 1'b1 :
		off_hit ? 1'b0 : on_r; // RULE_06 RULE_09
	assign on_out  = on_r;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
			cnt_r  <= '0;
			on_r   <= 1'b0;
		end else begin
			meta_r <= cmp_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
			cnt_r  <= cnt_nxt;
			on_r   <= on_nxt;
		end
	end

endmodule

module mqual_top
	import mqual_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
) (
	input  wire logic                     clk_in,
	input  wire logic                     reset_n_in,
	input  wire mqual_cmp_t [NUM_RED-1:0] red_cmp_in,
	input  wire mqual_cmp_t [NUM_CH-1:0]  green_cmp_in,
	input  wire mqual_cmp_t [NUM_CH-1:0]  yellow_cmp_in,
	input  wire mqual_cmp_t               sf1_cmp_in,
	input  wire mqual_cmp_t               sf2_cmp_in,
	input  wire mqual_cmp_t               red_enable_cmp_in,
	input  wire logic                     relay_common_active_in,
	input  wire logic                     red_interface_cable_in,
	input  wire logic                     front_reset_in,
	input  wire logic                     remote_reset_in,
	input  wire logic                     detector_fault_in,
	input  wire logic [ADDR_W-1:0]        reg_addr_in,
	input  wire logic [DATA_W-1:0]        reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	output logic      [DATA_W-1:0]        reg_rdata_out,
	output logic      [NUM_RED-1:0]       red_on_out,
	output logic      [NUM_CH-1:0]        green_on_out,
	output logic      [NUM_CH-1:0]        yellow_on_out,
	output logic                          inhibit_active_out,
	output logic                          red_fail_mon_en_out,
	output logic                          fault_flash_out,
	output logic                          irq_out
);

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

	// Millisecond tick divider
	logic [DIV_W-1:0] div_r;
	logic             tick_r;
	wire              div_wrap;

	assign div_wrap = (div_r == DIV_LAST);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r  <= div_wrap ? '0 : div_r + DIV_W'(1);
			tick_r <= div_wrap;
		end
	end

	// Field input qualifiers
	logic sf1_on;
	logic sf2_on;
	logic red_en_on;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_RED; gi++) begin : g_red
			mqual_filter #(
				.ON_MS  (RED_ON_MS),
				.OFF_MS (RED_OFF_MS)
			) u_red (
				.clk_in     (clk_in),
				.reset_n_in (reset_n_in),
				.tick_in    (tick_r),
				.cmp_in     (red_cmp_in[gi]), // RULE_01
				.on_out     (red_on_out[gi])
			);
		end
		for (gi = 0; gi < NUM_CH; gi++) begin : g_gy
			mqual_filter #(
				.ON_MS  (GY_ON_MS),
				.OFF_MS (GY_OFF_MS)
			) u_grn (
				.clk_in     (clk_in),
				.reset_n_in (reset_n_in),
				.tick_in    (tick_r),
				.cmp_in     (green_cmp_in[gi]),
				.on_out     (green_on_out[gi])
			);
			mqual_filter #(
				.ON_MS  (GY_ON_MS),
				.OFF_MS (GY_OFF_MS)
			) u_yel (
				.clk_in     (clk_in),
				.reset_n_in (reset_n_in),
				.tick_in    (tick_r),
				.cmp_in     (yellow_cmp_in[gi]),
				.on_out     (yellow_on_out[gi])
			);
		end
	endgenerate

	mqual_filter #(
		.ON_MS  (INH_ON_MS),
		.OFF_MS (INH_OFF_MS)
	) u_sf1 (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.tick_in    (tick_r),
		.cmp_in     (sf1_cmp_in), // RULE_04 RULE_05
		.on_out     (sf1_on)
	);

	mqual_filter #(
		.ON_MS  (INH_ON_MS),
		.OFF_MS (INH_OFF_MS)
	) u_sf2 (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.tick_in    (tick_r),
		.cmp_in     (sf2_cmp_in), // RULE_04 RULE_05
		.on_out     (sf2_on)
	);

	mqual_filter #(
		.ON_MS  (RED_ON_MS),
		.OFF_MS (RED_OFF_MS)
	) u_red_en (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.tick_in    (tick_r),
		.cmp_in     (red_enable_cmp_in), // RULE_14
		.on_out     (red_en_on)
	);

	// Pin synchronisers; cable slot resets to present
	logic [PIN_W-1:0] pin_meta_r;
	logic [PIN_W-1:0] pin_sync_r;
	logic [PIN_W-1:0] pin_prev_r;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_meta_r <= PIN_RST;
			pin_sync_r <= PIN_RST;
			pin_prev_r <= PIN_RST;
		end else begin
			pin_meta_r <= {remote_reset_in, front_reset_in,
				red_interface_cable_in, relay_common_active_in};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	// Register decode
	wire wr_ctrl;
	wire wr_status;
	wire wr_mask;

	assign wr_ctrl   = reg_wr_in && (reg_addr_in == REG_CTRL);
	assign wr_status = reg_wr_in && (reg_addr_in == REG_STATUS);
	assign wr_mask   = reg_wr_in && (reg_addr_in == REG_MASK);

	// Fault latch
	logic             fault_r;
	logic [CTRL_W-1:0] ctrl_r;
	wire              cable_lost;
	wire              reset_edge;
	wire              soft_clear;
	wire              fault_set;
	wire              fault_clr;
	wire              fault_nxt;

	assign cable_lost = !pin_sync_r[PIN_CABLE];
	assign reset_edge =
		(pin_sync_r[PIN_FRONT] && !pin_prev_r[PIN_FRONT]) ||
		(pin_sync_r[PIN_REMOTE] && !pin_prev_r[PIN_REMOTE]);
	assign soft_clear = wr_ctrl && reg_wdata_in[CTRL_CLEAR_BIT];
	assign fault_set  = cable_lost || detector_fault_in; // RULE_02
	assign fault_clr  = reset_edge || soft_clear; // RULE_12
	// Set wins, so a missing cable keeps the fault
	assign fault_nxt  = fault_set || (fault_r && !fault_clr); // RULE_12

	// Red-fail monitoring gate
	wire inhibit;
	wire mon_en_nxt;

	assign inhibit    = sf1_on || sf2_on; // RULE_03
	assign mon_en_nxt = red_en_on && !inhibit &&
		!pin_sync_r[PIN_RELAY] && ctrl_r[CTRL_ALLOW_BIT]; // RULE_13

	logic inhibit_r;
	logic mon_en_r;

	// Events into sticky status
	logic [STS_W-1:0] sts_r;
	logic [STS_W-1:0] mask_r;
	logic             irq_r;
	wire  [STS_W-1:0] events;
	wire  [STS_W-1:0] w1c;
	wire  [STS_W-1:0] sts_nxt;

	assign events[STS_CABLE_LOST] = cable_lost && pin_prev_r[PIN_CABLE];
	assign events[STS_FAULT]      = fault_nxt && !fault_r;
	assign events[STS_INHIBIT]    = inhibit && !inhibit_r;
	assign events[STS_RESET]      = reset_edge;
	assign w1c     = wr_status ? reg_wdata_in[STS_W-1:0] : '0;
	assign sts_nxt = (sts_r & ~w1c) | events;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fault_r   <= 1'b0;
			inhibit_r <= 1'b0;
			mon_en_r  <= 1'b0;
			ctrl_r    <= CTRL_RST;
			sts_r     <= STS_RST;
			mask_r    <= MASK_RST;
			irq_r     <= 1'b0;
		end else begin
			fault_r   <= fault_nxt;
			inhibit_r <= inhibit;
			mon_en_r  <= mon_en_nxt;
			// Clear bit is a strobe, only allow is kept
			if (wr_ctrl) begin
				ctrl_r[CTRL_ALLOW_BIT] <= reg_wdata_in[CTRL_ALLOW_BIT];
			end
			sts_r     <= sts_nxt;
			if (wr_mask) begin
				mask_r <= reg_wdata_in[STS_W-1:0];
			end
			irq_r     <= |(sts_r & mask_r);
		end
	end

	// Read-back
	mqual_state_t     state_v;
	logic [DATA_W-1:0] rdata_r;
	wire  [DATA_W-1:0] rd_mux;

	assign state_v = '{red_fail_mon: mon_en_r,
		relay_common: pin_sync_r[PIN_RELAY], red_en: red_en_on,
		sf2: sf2_on, sf1: sf1_on, cable_ok: !cable_lost,
		fault: fault_r};
	assign rd_mux =
		(reg_addr_in == REG_CTRL)   ?
			DATA_W'({1'b0, ctrl_r[CTRL_ALLOW_BIT]}) :
		(reg_addr_in == REG_STATUS) ? DATA_W'(sts_r) :
		(reg_addr_in == REG_MASK)   ? DATA_W'(mask_r) :
		(reg_addr_in == REG_STATE)  ? DATA_W'(state_v) :
		(reg_addr_in == REG_RED_ON) ? DATA_W'(red_on_out) :
		(reg_addr_in == REG_GRN_ON) ? DATA_W'(green_on_out) :
		(reg_addr_in == REG_YEL_ON) ? DATA_W'(yellow_on_out) :
		'0;

	// Read data stand one cycle, zero otherwise
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= reg_rd_in ? rd_mux : '0;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_out       = rdata_r;
	assign inhibit_active_out  = inhibit_r;
	assign red_fail_mon_en_out = mon_en_r;
	assign fault_flash_out     = fault_r; // RULE_02
	assign irq_out             = irq_r;

endmodule

// ==== verif/mqual_field_model.sv ====
module mqual_field_model
	import mqual_pkg::*;
#(
	parameter int unsigned N  = NUM_RED,
	parameter int unsigned HI = 70,
	parameter int unsigned LO = 50
) (
	input  wire logic [N-1:0][7:0] volts_in,
	output mqual_cmp_t [N-1:0]     cmp_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Mid band raises neither comparator bit
	always_comb begin
		for (int i = 0; i < N; i++) begin
			cmp_out[i].above_hi = volts_in[i] > HI;
			cmp_out[i].below_lo = volts_in[i] < LO;
		end
	end
endmodule

// ==== verif/mqual_top_bench.sv ====
module mqual_top_bench
	import mqual_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                         clk_in;
	logic                         reset_n_in;
	logic [NUM_RED-1:0][7:0]      rv;
	logic [NUM_CH-1:0][7:0]       gv;
	logic [NUM_CH-1:0][7:0]       yv;
	logic [2:0][7:0]              mv;
	wire mqual_cmp_t [NUM_RED-1:0] red_cmp_in;
	wire mqual_cmp_t [NUM_CH-1:0]  green_cmp_in;
	wire mqual_cmp_t [NUM_CH-1:0]  yellow_cmp_in;
	wire mqual_cmp_t [2:0]         mc;
	logic                         relay_common_active_in;
	logic                         red_interface_cable_in;
	logic                         front_reset_in;
	logic                         remote_reset_in;
	logic                         detector_fault_in;
	logic [ADDR_W-1:0]            reg_addr_in;
	logic [DATA_W-1:0]            reg_wdata_in;
	logic                         reg_wr_in;
	logic                         reg_rd_in;
	logic [DATA_W-1:0]            reg_rdata_out;
	logic [NUM_RED-1:0]           red_on_out;
	logic [NUM_CH-1:0]            green_on_out;
	logic [NUM_CH-1:0]            yellow_on_out;
	logic                         inhibit_active_out;
	logic                         red_fail_mon_en_out;
	logic                         fault_flash_out;
	logic                         irq_out;
	logic [15:0]                  lf;
	logic [15:0]                  pr;
	logic [17:0]                  pg;
	logic [17:0]                  py;
	int                           fail_count;
	int                           cmp_count;

	localparam int unsigned GY_N = 2 * NUM_CH;

	mqual_field_model #(.N(NUM_RED)) u_red (.volts_in(rv), .cmp_out(red_cmp_in));
	// Green and yellow share one model, green in the low half
	mqual_field_model #(.N(GY_N), .HI(25), .LO(15)) u_gy (
		.volts_in({yv, gv}), .cmp_out({yellow_cmp_in, green_cmp_in}));
	mqual_field_model #(.N(3)) u_misc (.volts_in(mv), .cmp_out(mc));

	mqual_top #(.TICK_CYCLES(10)) u_dut (
		.clk_in, .reset_n_in, .red_cmp_in, .green_cmp_in, .yellow_cmp_in,
		.sf1_cmp_in(mc[0]), .sf2_cmp_in(mc[1]), .red_enable_cmp_in(mc[2]),
		.relay_common_active_in, .red_interface_cable_in, .front_reset_in,
		.remote_reset_in, .detector_fault_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .red_on_out, .green_on_out,
		.yellow_on_out, .inhibit_active_out, .red_fail_mon_en_out,
		.fault_flash_out, .irq_out);

	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		wt(1);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a, input logic [31:0] e);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		wt(1);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, e);
		wt(1);
	endtask

	task automatic lvl(input logic [7:0] r, input logic [7:0] g);
		rv <= {NUM_RED{r}};
		gv <= {NUM_CH{g}};
		yv <= {NUM_CH{g}};
	endtask

	task automatic pls(input logic fr);
		front_reset_in <= fr;
		remote_reset_in <= !fr;
		wt(4);
		front_reset_in <= 1'b0;
		remote_reset_in <= 1'b0;
		wt(8);
	endtask

	task automatic close_out;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	initial begin
		#8_000_000;
		fail_count++;
		close_out;
	end

	initial begin
		reset_n_in = 1'b0;
		rv = '0;
		gv = '0;
		yv = '0;
		mv = '0;
		relay_common_active_in = 1'b0;
		red_interface_cable_in = 1'b1;
		front_reset_in = 1'b0;
		remote_reset_in = 1'b0;
		detector_fault_in = 1'b0;
		reg_addr_in = '0;
		reg_wdata_in = '0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		lf = nx(16'h6F39);
		pr = lf | 16'h0001;
		lf = nx(lf);
		pg = {lf[1:0], lf} | 18'h0_0001;
		lf = nx(lf);
		py = {lf[15:14], lf};
		wt(4);
		reset_n_in <= 1'b1;
		rdr(REG_CTRL, 32'(CTRL_RST));
		rdr(8'h40, 32'h0000_0000);
		mv[2] <= 8'h50;
		for (int i = 0; i < NUM_CH; i++) begin
			if (i < NUM_RED) begin
				rv[i] <= pr[i] ? 8'h50 : 8'h1E;
			end
			gv[i] <= pg[i] ? 8'h1E : 8'h0A;
			yv[i] <= py[i] ? 8'h1E : 8'h0A;
		end
		wt(5400);
		chk(32'(red_on_out), 32'(pr));
		chk(32'(green_on_out), 32'(pg));
		chk(32'(yellow_on_out), 32'(py));
		chk(32'(red_fail_mon_en_out), 32'h0000_0001);
		rdr(REG_RED_ON, 32'(pr));
		rdr(REG_GRN_ON, 32'(pg));
		rdr(REG_YEL_ON, 32'(py));
		rdr(REG_STATE, 32'h0000_0052);
		lvl(8'h00, 8'h00);
		wt(2300);
		chk(32'(red_on_out), 32'h0000_0000);
		chk(32'(green_on_out | yellow_on_out), 32'h0000_0000);
		lvl(8'h50, 8'h1E);
		wt(1500);
		lvl(8'h00, 8'h00);
		wt(3000);
		chk(32'(red_on_out), 32'h0000_0000);
		chk(32'(green_on_out | yellow_on_out), 32'h0000_0000);
		mv[1] <= 8'h50;
		wt(2000);
		mv[1] <= 8'h00;
		wt(600);
		chk(32'(inhibit_active_out), 32'h0000_0000);
		mv[0] <= 8'h50;
		wt(5800);
		chk(32'(inhibit_active_out), 32'h0000_0001);
		chk(32'(red_fail_mon_en_out), 32'h0000_0000);
		mv[0] <= 8'h00;
		wt(2800);
		chk(32'(red_fail_mon_en_out), 32'h0000_0001);
		wr(REG_CTRL, 32'h0000_0000);
		wt(2);
		chk(32'(red_fail_mon_en_out), 32'h0000_0000);
		wr(REG_CTRL, 32'h0000_0001);
		relay_common_active_in <= 1'b1;
		wt(6);
		chk(32'(red_fail_mon_en_out), 32'h0000_0000);
		relay_common_active_in <= 1'b0;
		wr(REG_MASK, 32'h0000_0001);
		red_interface_cable_in <= 1'b0;
		wt(8);
		chk(32'(fault_flash_out), 32'h0000_0001);
		chk(32'(irq_out), 32'h0000_0001);
		pls(1'b1);
		chk(32'(fault_flash_out), 32'h0000_0001);
		red_interface_cable_in <= 1'b1;
		wt(6);
		pls(1'b0);
		chk(32'(fault_flash_out), 32'h0000_0000);
		rdr(REG_STATUS, 32'h0000_000F);
		wr(REG_STATUS, 32'h0000_000F);
		wt(3);
		chk(32'(irq_out), 32'h0000_0000);
		detector_fault_in <= 1'b1;
		wt(1);
		detector_fault_in <= 1'b0;
		wt(4);
		chk(32'(fault_flash_out), 32'h0000_0001);
		wr(REG_CTRL, 32'h0000_0003);
		wt(4);
		chk(32'(fault_flash_out), 32'h0000_0000);
		close_out;
	end
endmodule

// ==== verif/mqual_top_monitor.sv ====
module mqual_top_monitor
	import mqual_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
) (
	input wire logic                     clk_in,
	input wire logic                     reset_n_in,
	input wire mqual_cmp_t [NUM_RED-1:0] red_cmp_in,
	input wire mqual_cmp_t [NUM_CH-1:0]  green_cmp_in,
	input wire mqual_cmp_t               sf1_cmp_in,
	input wire mqual_cmp_t               sf2_cmp_in,
	input wire logic                     relay_common_active_in,
	input wire logic                     red_interface_cable_in,
	input wire logic                     front_reset_in,
	input wire logic                     remote_reset_in,
	input wire logic                     reg_wr_in,
	input wire logic [NUM_RED-1:0]       red_on_out,
	input wire logic [NUM_CH-1:0]        green_on_out,
	input wire logic                     inhibit_active_out,
	input wire logic                     red_fail_mon_en_out,
	input wire logic                     fault_flash_out
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned RON = RED_ON_MS * TICK_CYCLES;
	localparam int unsigned ROF = RED_OFF_MS * TICK_CYCLES;
	localparam int unsigned GON = GY_ON_MS * TICK_CYCLES;
	localparam int unsigned ION = INH_ON_MS * TICK_CYCLES;

	mqual_cmp_t  pin_w [4];
	mqual_cmp_t  pin_r [4];
	logic [19:0] run_r [4];
	logic [4:0]  age_r;

	assign pin_w[0] = red_cmp_in[0];
	assign pin_w[1] = green_cmp_in[0];
	assign pin_w[2] = sf1_cmp_in;
	assign pin_w[3] = sf2_cmp_in;

	// Cycles since each watched pin pair last changed
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < 4; i++) begin
				pin_r[i] <= '0;
				run_r[i] <= 20'h0_0000;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				pin_r[i] <= pin_w[i];
				run_r[i] <= (pin_w[i] != pin_r[i]) ? 20'h0_0000 :
					(run_r[i] == 20'hF_FFFF) ? run_r[i] :
					run_r[i] + 20'h0_0001;
			end
		end
	end

	// Recent clear request window
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			age_r <= 5'h00;
		end else if (front_reset_in || remote_reset_in || reg_wr_in) begin
			age_r <= 5'h10;
		end else if (age_r != 5'h00) begin
			age_r <= age_r - 5'h01;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	AST_CABLE_FLASH: assert property (
		!red_interface_cable_in [*5] |-> fault_flash_out)
		else $error("no flash with cable out");
	AST_FAULT_HOLD: assert property (
		$fell(fault_flash_out) |-> age_r != 5'h00)
		else $error("fault dropped without reset");
	AST_INH_MON: assert property (
		inhibit_active_out [*2] |-> !red_fail_mon_en_out)
		else $error("red-fail mon on during inhibit");
	AST_RELAY_MON: assert property (
		relay_common_active_in [*4] |-> !red_fail_mon_en_out)
		else $error("red-fail mon on with relay common");
	AST_RED_ON_MIN: assert property (
		$rose(red_on_out[0]) |-> run_r[0] >= RON)
		else $error("red on too early");
	AST_RED_ON_MAX: assert property (
		pin_r[0] == 2'b10 && run_r[0] == RON + 3 * TICK_CYCLES
		|-> red_on_out[0])
		else $error("red on too late");
	AST_RED_OFF_MIN: assert property (
		$fell(red_on_out[0]) |-> run_r[0] >= ROF)
		else $error("red off too early");
	AST_GRN_ON_MIN: assert property (
		$rose(green_on_out[0]) |-> run_r[1] >= GON)
		else $error("green on too early");
	AST_INH_ON_MIN: assert property (
		$rose(inhibit_active_out) |-> run_r[2] >= ION || run_r[3] >= ION)
		else $error("inhibit active too early");

	COV_FAULT: cover property ($rose(fault_flash_out));
	COV_INH: cover property ($rose(inhibit_active_out));
	COV_RED: cover property ($fell(red_on_out[0]));
endmodule

bind mqual_top mqual_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.clk_in, .reset_n_in, .red_cmp_in, .green_cmp_in, .sf1_cmp_in,
	.sf2_cmp_in, .relay_common_active_in, .red_interface_cable_in,
	.front_reset_in, .remote_reset_in, .reg_wr_in, .red_on_out,
	.green_on_out, .inhibit_active_out, .red_fail_mon_en_out,
	.fault_flash_out
);
